// ==== design/tsmap_params.svh ====
`ifndef TSMAP_PARAMS_SVH
`define TSMAP_PARAMS_SVH

// Map register byte offsets
`define MAP_WORD_FIRST    7'h00
`define MAP_WORD_S28      7'h1C
`define MAP_WORD_S60      7'h3C
`define MAP_WORD_S92      7'h5C
`define MAP_WORD_LAST     7'h7C

// Map geometry
`define MAP_WORDS         32
`define MAP_SLOTS         128
`define MAP_RESET         32'h0000_0000
`define MAP_ONES          32'hFFFF_FFFF

// Slot entry fields
`define ENT_MODE_MSB      7
`define ENT_MODE_LSB      5
`define ENT_CH_MSB        4
`define ENT_CH_LSB        0

// Last slot per framing mode
`define LAST_T1           7'h17
`define LAST_E1           7'h1F
`define LAST_2E1          7'h3F
`define LAST_4E1          7'h7F

// Line clock loss timing
`define SYS_CLK_PS        4000
`define LINE_LOSS_NS      1000
`define LINE_LOSS_CYC     ((`LINE_LOSS_NS * 1000) / `SYS_CLK_PS)

// Receive buffer
`define RX_FIFO_DEPTH     8
`define RX_FIFO_WIDTH     12

`endif

// ==== design/tsmap_pkg.sv ====
package tsmap_pkg;

    // Slot mode codes
    typedef enum logic [2:0] {
        MODE_DISABLED = 3'h0,
        MODE_64K      = 3'h4,
        MODE_56K      = 3'h5,
        MODE_SUB_NO0  = 3'h6,
        MODE_SUB_W0   = 3'h7
    } slot_mode_t;

    // Serial port framing modes
    typedef enum logic [2:0] {
        PM_T1   = 3'h0,
        PM_E1   = 3'h1,
        PM_2E1  = 3'h2,
        PM_4E1  = 3'h3,
        PM_NX64 = 3'h4
    } port_mode_t;

    // Link tracking states
    typedef enum logic [1:0] {
        LINK_DOWN = 2'h0,
        LINK_HUNT = 2'h1,
        LINK_UP   = 2'h3
    } link_state_t;

endpackage

// ==== design/tdm_timeslot_channel_map.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tsmap_params.svh"

// Behaviour
// - 32 words map 128 slots per direction
// - Any active slot count 1 to 128
// - Map used only in channelized framing modes
// - Channel number 5 bits, 0 to 31
// - Each slot routes to one channel
// - Join 2 or 4 groups for more channels
// - Separate transmit and receive maps
// - 128 eight-bit entries per map
// - Disabled slot routes nothing, values kept
// - 64 kbps routes all eight bits
// - 56 kbps routes low seven bits only
// - Subchannel no bit0: LSB dropped, rest indexed
// - Subchannel with bit0: LSB direct, rest indexed
// - No line clock: writes dropped, reads ones
// - Receive map read/write, transmit reads ones
// - Byte k: mode top three, channel low five
// - Mode codes 0,4,5,6,7; 1-3 reserved
// - Slots 4n..4n+3 at offset 4n, LSB first
// - Channel and bit form subchannel index
// - Nx64 sync resets slot counter

//----------------------------------------------------------
// Buffer
//----------------------------------------------------------
module tsmap_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    // Handshakes and pointers
    always_comb begin
        in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
        out_valid_out = (cnt_q != '0);
        push = in_valid_in && in_ready_out;
        pop  = out_valid_out && out_ready_in;
        wp_d = push ? wp_q + AW'(1) : wp_q;
        rp_d = pop ? rp_q + AW'(1) : rp_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Pointer registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wp_q] <= in_data_in;
        end
    end
    assign out_data_out = mem_q[rp_q];
endmodule // tsmap_fifo

//----------------------------------------------------------
// Slot map
//----------------------------------------------------------
module tdm_timeslot_channel_map (
    // Clock and reset
    input  wire logic                   sys_clk_in,
    input  wire logic                   arst_n_in,
    // Host map access
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    input  wire logic                   reg_tx_sel_in,
    input  wire logic [6:0]             reg_addr_in,
    input  wire logic [31:0]            reg_wdata_in,
    output logic [31:0]                 reg_rdata_out,
    output logic                        reg_ack_out,
    // Port configuration
    input  wire tsmap_pkg::port_mode_t  port_framing_mode_in,
    input  wire logic [1:0]             group_join_in,
    // Serial line
    input  wire logic                   line_clk_in,
    input  wire logic                   line_sync_in,
    input  wire logic                   line_rx_data_in,
    // Receive bit stream out
    output logic                        rx_valid_out,
    input  wire logic                   rx_ready_in,
    output logic [11:0]                 rx_data_out,
    output logic                        rx_overrun_out,
    // Transmit routing
    output logic                        tx_route_valid_out,
    output logic                        tx_route_sub_out,
    output logic [9:0]                  tx_route_index_out,
    // Status
    output logic                        line_clk_ok_out
);
    import tsmap_pkg::*;
    //------------------------------------------------------
    // Reset and input synchronisers
    //------------------------------------------------------
    logic       rst_s1_q, rst_n;
    logic [2:0] sy1_q, sy2_q;
    logic       lclk_d3_q;

    // Reset release
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end
    // Two stages for clock, sync, data
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sy1_q     <= 3'h0;
            sy2_q     <= 3'h0;
            lclk_d3_q <= 1'b0;
        end else begin
            sy1_q     <= {line_rx_data_in, line_sync_in, line_clk_in};
            sy2_q     <= sy1_q;
            lclk_d3_q <= sy2_q[0];
        end
    end
    logic lclk_rise, sync_now, rx_bit;
    assign lclk_rise = sy2_q[0] && !lclk_d3_q;
    assign sync_now  = sy2_q[1];
    assign rx_bit    = sy2_q[2];
    //------------------------------------------------------
    // Routing of one bit
    //------------------------------------------------------
    // Returns {enable, sub, index[7:0]}
    function automatic logic [9:0] route(input logic [7:0] ent,
                                         input logic [2:0] b);
        logic [2:0] md;
        logic [4:0] ch;
        logic       en, sb;
        md = ent[`ENT_MODE_MSB:`ENT_MODE_LSB];
        ch = ent[`ENT_CH_MSB:`ENT_CH_LSB];
        en = 1'b0;
        sb = 1'b0;
        case (md)
            MODE_64K: en = 1'b1;
            MODE_56K: en = (b != 3'h7);
            MODE_SUB_NO0: begin
                en = (b != 3'h0);
                sb = 1'b1;
            end
            MODE_SUB_W0: begin
                en = 1'b1;
                sb = (b != 3'h0);
            end
            default: en = 1'b0;
        endcase
        // Subchannel index is channel then bit
        return {en, sb, sb ? {ch, b} : {3'h0, ch}};
    endfunction
    //------------------------------------------------------
    // Link tracking and counters
    //------------------------------------------------------
    link_state_t st_q, st_d;
    logic [8:0]  loss_q, loss_d;
    logic [2:0]  bit_q, bit_d, cur_bit;
    logic [6:0]  slot_q, slot_d, cur_slot, last_slot;
    logic        resync, map_on;

    // Frame length per framing mode
    always_comb begin
        case (port_framing_mode_in)
            PM_T1:   last_slot = `LAST_T1;
            PM_E1:   last_slot = `LAST_E1;
            PM_2E1:  last_slot = `LAST_2E1;
            default: last_slot = `LAST_4E1;
        endcase
    end
    // Sync realigns in Nx64 always, else only while the link is down or hunting
    assign resync = sync_now && ((port_framing_mode_in == PM_NX64)
                    || (st_q != LINK_UP));
    assign cur_bit  = resync ? 3'h0 : bit_q;
    assign cur_slot = resync ? 7'h00 : slot_q;

    // Next state, loss timer and counters
    always_comb begin
        st_d   = st_q;
        loss_d = loss_q;
        bit_d  = bit_q;
        slot_d = slot_q;
        if (lclk_rise) begin
            loss_d = 9'h000;
            bit_d  = cur_bit + 3'h1;
            slot_d = cur_slot;
            if (cur_bit == 3'h7) begin
                // Short frames wrap early
                slot_d = (cur_slot >= last_slot) ? 7'h00
                         : cur_slot + 7'h01;
            end
        end else if (loss_q != 9'(`LINE_LOSS_CYC)) begin
            loss_d = loss_q + 9'h001;
        end
        case (st_q)
            LINK_DOWN: if (lclk_rise) st_d = LINK_HUNT;
            LINK_HUNT: begin
                if (lclk_rise && sync_now) st_d = LINK_UP;
                else if (loss_d == 9'(`LINE_LOSS_CYC)) st_d = LINK_DOWN;
            end
            LINK_UP: if (loss_d == 9'(`LINE_LOSS_CYC)) st_d = LINK_DOWN;
            default: st_d = LINK_DOWN;
        endcase
    end

    // Link registers
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= LINK_DOWN;
            loss_q <= 9'h000;
            bit_q  <= 3'h0;
            slot_q <= 7'h00;
        end else begin
            st_q   <= st_d;
            loss_q <= loss_d;
            bit_q  <= bit_d;
            slot_q <= slot_d;
        end
    end

    // Map applies only in channelized modes on a live link
    assign map_on = (st_q == LINK_UP) &&
                    (port_framing_mode_in <= PM_NX64);
    assign line_clk_ok_out = (st_q != LINK_DOWN);
    //------------------------------------------------------
    // Map storage and host access
    //------------------------------------------------------
    logic [`MAP_WORDS-1:0][31:0] rx_map_q, rx_map_d;
    logic [`MAP_WORDS-1:0][31:0] tx_map_q, tx_map_d;
    logic [4:0]  widx;
    logic [31:0] rdata_d;
    logic        ack_d;

    // Offset 4n holds slots 4n..4n+3
    assign widx = reg_addr_in[6:2];
    // Writes, dropped without line clock
    always_comb begin
        rx_map_d = rx_map_q;
        tx_map_d = tx_map_q;
        ack_d    = reg_wr_in || reg_rd_in;
        rdata_d  = `MAP_ONES;
        if (reg_wr_in && line_clk_ok_out) begin
            if (reg_tx_sel_in) tx_map_d[widx] = reg_wdata_in;
            else rx_map_d[widx] = reg_wdata_in;
        end
        if (reg_rd_in && line_clk_ok_out && !reg_tx_sel_in) begin
            rdata_d = rx_map_q[widx];
        end
    end

    // Map and read data registers
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rx_map_q      <= {`MAP_WORDS{`MAP_RESET}};
            tx_map_q      <= {`MAP_WORDS{`MAP_RESET}};
            reg_rdata_out <= `MAP_ONES;
            reg_ack_out   <= 1'b0;
        end else begin
            rx_map_q      <= rx_map_d;
            tx_map_q      <= tx_map_d;
            reg_rdata_out <= rdata_d;
            reg_ack_out   <= ack_d;
        end
    end
    //------------------------------------------------------
    // Lookup and receive buffer
    //------------------------------------------------------
    logic [7:0]  rx_ent, tx_ent;
    logic [9:0]  rx_rt, tx_rt;
    logic [1:0]  grp;
    logic        push, fill_ready;
    logic [11:0] push_word;

    // 8-bit entry, lowest slot in low byte
    assign rx_ent = rx_map_q[cur_slot[6:2]][{cur_slot[1:0], 3'h0} +: 8];
    assign tx_ent = tx_map_q[cur_slot[6:2]][{cur_slot[1:0], 3'h0} +: 8];
    assign rx_rt  = route(rx_ent, cur_bit);
    assign tx_rt  = route(tx_ent, cur_bit);

    // Joined groups take the group from the slot's upper bits
    assign grp = (group_join_in == 2'h2) ? cur_slot[6:5]
               : (group_join_in == 2'h1) ? {1'b0, cur_slot[5]}
               : 2'h0;
    assign push      = lclk_rise && map_on && rx_rt[9];
    assign push_word = {grp, rx_rt[8:0], rx_bit};

    tsmap_fifo #(
        .WIDTH (`RX_FIFO_WIDTH),
        .DEPTH (`RX_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_in        (sys_clk_in),
        .rst_n_in      (rst_n),
        .in_valid_in   (push),
        .in_ready_out  (fill_ready),
        .in_data_in    (push_word),
        .out_valid_out (rx_valid_out),
        .out_ready_in  (rx_ready_in),
        .out_data_out  (rx_data_out)
    );

    logic       ovr_d, txv_d, txs_d;
    logic [9:0] txi_d;
    // Transmit routing and overrun
    always_comb begin
        ovr_d = push && !fill_ready;
        txv_d = lclk_rise && map_on && tx_rt[9];
        txs_d = tx_rt[8];
        txi_d = {grp, tx_rt[7:0]};
    end

    // Output registers
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rx_overrun_out     <= 1'b0;
            tx_route_valid_out <= 1'b0;
            tx_route_sub_out   <= 1'b0;
            tx_route_index_out <= 10'h000;
        end else begin
            rx_overrun_out     <= ovr_d;
            tx_route_valid_out <= txv_d;
            tx_route_sub_out   <= txs_d;
            tx_route_index_out <= txi_d;
        end
    end
    //------------------------------------------------------
    // Checks
    //------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n);

    a_tx_read_ones: assert property (
        reg_rd_in && reg_tx_sel_in |=> reg_rdata_out == `MAP_ONES)
        else $error("transmit map read not all ones");
    a_noclk_read_ones: assert property (
        reg_rd_in && !line_clk_ok_out |=> reg_rdata_out == `MAP_ONES)
        else $error("read without line clock not all ones");
    a_noclk_write_drop: assert property (
        reg_wr_in && !line_clk_ok_out |=>
        $stable(rx_map_q) && $stable(tx_map_q))
        else $error("write without line clock changed map");
    a_rx_write_back: assert property (
        reg_wr_in && line_clk_ok_out && !reg_tx_sel_in |=>
        rx_map_q[$past(widx)] == $past(reg_wdata_in))
        else $error("receive map write not stored");
    a_push_enabled: assert property (
        push |-> rx_ent[7] && map_on)
        else $error("disabled or reserved slot routed");
    a_56k_msb_drop: assert property (
        push && rx_ent[7:5] == MODE_56K |-> cur_bit != 3'h7)
        else $error("56k slot routed its MSB");
    a_sub_lsb_drop: assert property (
        push && rx_ent[7:5] == MODE_SUB_NO0 |-> cur_bit != 3'h0)
        else $error("subchannel slot routed its LSB");
    a_nx64_sync_zero: assert property (
        lclk_rise && sync_now && port_framing_mode_in == PM_NX64
        |=> slot_q == 7'h00 && bit_q == 3'h1)
        else $error("Nx64 sync did not clear slot counter");
    a_t1_slot_bound: assert property (
        port_framing_mode_in == PM_T1 && $stable(port_framing_mode_in)
        && $past(slot_q) < 7'd24 |-> slot_q < 7'd24)
        else $error("T1 slot counter passed 24 slots");
    c_sub_push: cover property (push && rx_rt[8]);
    c_overrun:  cover property (rx_overrun_out);
    c_link_up:  cover property (st_q == LINK_HUNT ##1 st_q == LINK_UP);
    c_tx_route: cover property (tx_route_valid_out && tx_route_sub_out);
endmodule // tdm_timeslot_channel_map

`default_nettype wire

// ==== sim/tdm_line_model.sv ====
`timescale 1ns/1ps
`default_nettype none

//----------------------------------------------------------
// Framer line model
//----------------------------------------------------------
module tdm_line_model (
    // Control
    input  wire logic       en_in,
    input  wire logic [7:0] nslots_in,
    // Serial line
    output logic            line_clk_out,
    output logic            line_sync_out,
    output logic            line_data_out
);
    int unsigned pos;
    logic [7:0]  cur;

    // Byte carried by each slot
    function automatic logic [7:0] slot_byte(input int s);
        return 8'(s * 37 + 90);
    endfunction

    // Clock runs only while enabled, sync and data launched on the fall
    initial begin
        line_clk_out  = 1'b0;
        line_sync_out = 1'b0;
        line_data_out = 1'b0;
        pos           = 0;
        forever begin
            #16;
            if (!en_in) begin
                line_sync_out = 1'b0;
                line_data_out = ~line_data_out; // Idle line wanders
            end else begin
                line_clk_out = ~line_clk_out;
                if (!line_clk_out) begin
                    line_sync_out = (pos == 0);
                    cur           = slot_byte(pos / 8);
                    line_data_out = cur[pos % 8]; // LSB first
                    pos           = (pos + 1) % (nslots_in * 8);
                end
            end
        end
    end
endmodule // tdm_line_model

`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tsmap_params.svh"

module tb;
    import tsmap_pkg::*;

    typedef struct packed {
        logic        wr;
        logic        tx;
        logic [6:0]  a;
        logic [31:0] d;
    } row_t;

    logic        sys_clk, arst_n, reg_wr, reg_rd, reg_tx_sel;
    logic [6:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, q;
    logic        reg_ack, line_clk, line_sync, line_data, line_en;
    logic        rx_valid, rx_ready, rx_overrun, tx_valid, tx_sub;
    logic        clk_ok;
    logic [11:0] rx_data;
    logic [9:0]  tx_index;
    logic [10:0] tx_idx;
    logic [7:0]  nslots;
    logic [1:0]  gjoin;
    port_mode_t  pmode;
    int          mismatches, checks, ovr, txn;
    logic [11:0] got[$], exp_q[$];
    logic [31:0] rx_map[32];
    port_mode_t  modes[3] = '{PM_T1, port_mode_t'(3'h5), PM_NX64};
    row_t        rows[10] = '{
        '{1'b1, 1'b0, 7'h00, 32'hE3A9_851F},
        '{1'b1, 1'b0, 7'h04, 32'h6322_41C7},
        '{1'b1, 1'b0, 7'h7C, 32'h8483_8281},
        '{1'b1, 1'b1, 7'h04, 32'h0000_00E2},
        '{1'b0, 1'b0, 7'h00, 32'hE3A9_851F},
        '{1'b0, 1'b0, 7'h05, 32'h6322_41C7},
        '{1'b0, 1'b0, 7'h7C, 32'h8483_8281},
        '{1'b0, 1'b1, 7'h04, 32'hFFFF_FFFF},
        '{1'b0, 1'b0, 7'h3C, 32'h0000_0000},
        '{1'b0, 1'b1, 7'h00, 32'hFFFF_FFFF}};

    tdm_timeslot_channel_map uut (
        .sys_clk_in(sys_clk), .arst_n_in(arst_n),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_tx_sel_in(reg_tx_sel),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_rdata_out(reg_rdata), .reg_ack_out(reg_ack),
        .port_framing_mode_in(pmode), .group_join_in(gjoin),
        .line_clk_in(line_clk), .line_sync_in(line_sync),
        .line_rx_data_in(line_data), .rx_valid_out(rx_valid),
        .rx_ready_in(rx_ready), .rx_data_out(rx_data),
        .rx_overrun_out(rx_overrun), .tx_route_valid_out(tx_valid),
        .tx_route_sub_out(tx_sub), .tx_route_index_out(tx_index),
        .line_clk_ok_out(clk_ok));

    tdm_line_model frm (
        .en_in(line_en), .nslots_in(nslots), .line_clk_out(line_clk),
        .line_sync_out(line_sync), .line_data_out(line_data));

    //------------------------------------------------------
    // Helpers
    //------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // One strobe, answer sampled the cycle after it is taken
    task automatic acc(input logic wr, input logic tx, input logic [6:0] a,
                       input logic [31:0] d);
        @(negedge sys_clk);
        {reg_wr, reg_rd, reg_tx_sel, reg_addr, reg_wdata} = {wr, !wr, tx, a, d};
        @(negedge sys_clk);
        {reg_wr, reg_rd} = 2'b00;
        chk(32'(reg_ack), 32'h0000_0001);
        q = reg_rdata;
    endtask

    task automatic wait_sync();
        @(posedge line_sync);
        @(negedge sys_clk);
    endtask

    task automatic wait_ok();
        for (int n = 0; n < 500 && clk_ok !== 1'b1; n++) @(negedge sys_clk);
    endtask

    // Words the receive side should push for one frame
    task automatic build(input logic off);
        logic [2:0] m;
        logic [4:0] ch;
        logic [7:0] b;
        logic [1:0] g;
        exp_q.delete();
        for (int s = 0; s < int'(nslots) && !off; s++) begin
            {m, ch} = rx_map[s / 4][8 * (s % 4) +: 8];
            b = 8'(s * 37 + 90);
            g = (gjoin == 2'h2) ? 2'(s / 32) : 2'h0;
            for (int i = 0; i < 8; i++) begin
                if (m == 3'h4 || (m == 3'h5 && i < 7) || (m == 3'h7 && i == 0))
                    exp_q.push_back({g, 1'b0, 3'b000, ch, b[i]});
                else if ((m == 3'h6 || m == 3'h7) && i > 0)
                    exp_q.push_back({g, 1'b1, ch, 3'(i), b[i]});
            end
        end
    endtask

    // Capture of drained words and routing pulses
    always @(posedge sys_clk) begin
        if (rx_valid && rx_ready) got.push_back(rx_data);
        if (rx_overrun) ovr++;
        if (tx_valid) begin
            txn++;
            tx_idx = {tx_sub, tx_index};
        end
    end

    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Watchdog
    initial begin
        #250_000;
        mismatches++;
        conclude();
    end

    //------------------------------------------------------
    // Tests
    //------------------------------------------------------
    initial begin
        {arst_n, reg_wr, reg_rd, reg_tx_sel, line_en} = 5'b00000;
        reg_addr = 7'h00;
        reg_wdata = 32'h0000_0000;
        pmode = PM_T1;
        nslots = 8'h18;
        gjoin = 2'h0;
        rx_ready = 1'b1;
        foreach (rx_map[i]) rx_map[i] = 32'h0000_0000;
        repeat (2) @(negedge sys_clk);
        chk({27'h0, reg_ack, rx_valid, rx_overrun, tx_valid, clk_ok}, 32'h0);
        chk(reg_rdata, `MAP_ONES);
        arst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        acc(1'b0, 1'b0, 7'h00, 32'h0);
        chk(q, `MAP_ONES);
        acc(1'b1, 1'b0, 7'h08, 32'h1234_5678);
        line_en = 1'b1;
        wait_ok();
        $display("test reset done");
        // Register rows
        foreach (rows[r]) begin
            acc(rows[r].wr, rows[r].tx, rows[r].a, rows[r].d);
            if (rows[r].wr && !rows[r].tx) rx_map[rows[r].a[6:2]] = rows[r].d;
            if (!rows[r].wr) chk(q, rows[r].d);
        end
        acc(1'b0, 1'b0, 7'h08, 32'h0);
        chk(q, 32'h0000_0000);
        $display("test registers done");
        // Routing for T1, unmapped mode code 5 and Nx64
        for (int m = 0; m < 3; m++) begin
            pmode = modes[m];
            wait_sync();
            wait_sync();
            got.delete();
            txn = 0;
            wait_sync();
            build(m == 1);
            chk(32'(got.size()), 32'(exp_q.size()));
            foreach (exp_q[i])
                if (i < got.size()) chk(32'(got[i]), 32'(exp_q[i]));
            chk(32'(txn), (m == 1) ? 32'h0 : 32'h8);
            if (m != 1) chk(32'(tx_idx), 32'h0000_0417);
            $display("test mode %0d done", m);
        end
        // Receive buffer full while drain stalls
        wait_sync();
        rx_ready = 1'b0;
        got.delete();
        ovr = 0;
        wait_sync();
        build(1'b0);
        chk(32'(ovr), 32'(exp_q.size() - `RX_FIFO_DEPTH));
        rx_ready = 1'b1;
        repeat (10) @(negedge sys_clk);
        chk(32'(got.size()), `RX_FIFO_DEPTH);
        foreach (got[i]) chk(32'(got[i]), 32'(exp_q[i]));
        $display("test overrun done");
        // Line clock loss
        line_en = 1'b0;
        repeat (300) @(negedge sys_clk);
        chk(32'(clk_ok), 32'h0);
        acc(1'b0, 1'b0, 7'h00, 32'h0);
        chk(q, `MAP_ONES);
        acc(1'b1, 1'b0, 7'h00, 32'h0);
        pmode = PM_4E1;
        nslots = 8'h80;
        gjoin = 2'h2;
        line_en = 1'b1;
        wait_ok();
        acc(1'b0, 1'b0, 7'h00, 32'h0);
        chk(q, 32'hE3A9_851F);
        $display("test loss done");
        // Four joined groups over a full 128 slot frame
        wait_sync();
        got.delete();
        wait_sync();
        build(1'b0);
        chk(32'(got.size()), 32'(exp_q.size()));
        foreach (exp_q[i])
            if (i < got.size()) chk(32'(got[i]), 32'(exp_q[i]));
        $display("test joined groups done");
        conclude();
    end
endmodule // tb

`default_nettype wire
